/* mcc_pkg.sv */
package mcc_pkg;

  // ---------------------------------------------------------------
  // Register map
  // ---------------------------------------------------------------
  // Bus address of the device; value is arbitrary
  localparam logic [6:0] MCC_DEV_ADDR = 7'h5A;
  localparam logic [7:0] MCC_ADDR_LO = 8'h30;
  localparam logic [7:0] MCC_ADDR_HI = 8'h31;
  localparam logic [7:0] MCC_UNMAPPED_READ = 8'h00;
  localparam logic [15:0] MCC_CFG_RESET = 16'h3F00;

  // ---------------------------------------------------------------
  // Field positions in the 16-bit word
  // ---------------------------------------------------------------
  localparam int MCC_BIT_BATTERY_CURRENT_MONITOR_OUTPUT_EN = 15;
  localparam int MCC_BIT_HOT_LP = 14;
  localparam int MCC_BIT_SYSTEM_POWER_MONITOR_OUTPUT_HI = 13;
  localparam int MCC_BIT_SYSTEM_POWER_MONITOR_OUTPUT_LO = 12;
  localparam int MCC_BIT_RIN = 11;
  localparam int MCC_BIT_RCHG = 10;
  localparam int MCC_BIT_GAIN = 9;
  localparam int MCC_BIT_COMPARATOR_REFERENCE_SELECT = 7;
  localparam int MCC_BIT_COMPARATOR_POLARITY_SELECT = 6;

  // System power monitor select codes
  localparam logic [1:0] MCC_SYSTEM_POWER_MONITOR_OUTPUT_BUS_BAT = 2'h0;
  localparam logic [1:0] MCC_SYSTEM_POWER_MONITOR_OUTPUT_BUS = 2'h1;
  localparam logic [1:0] MCC_SYSTEM_POWER_MONITOR_OUTPUT_RSVD = 2'h2;
  localparam logic [1:0] MCC_SYSTEM_POWER_MONITOR_OUTPUT_OFF = 2'h3;

  // Input current reading step in mA
  localparam logic [7:0] MCC_IIN_LSB_10MOHM = 8'h32;
  localparam logic [7:0] MCC_IIN_LSB_5MOHM = 8'h64;

  // ---------------------------------------------------------------
  // Serial bus engine
  // ---------------------------------------------------------------
  localparam logic [3:0] MCC_BYTE_BITS = 4'h8;
  localparam int MCC_SYNC_WIDTH = 4;

  typedef enum logic [7:0] {
    MCC_ST_IDLE  = 8'h01,
    MCC_ST_ADDR  = 8'h02,
    MCC_ST_AACK  = 8'h04,
    MCC_ST_WRITE = 8'h08,
    MCC_ST_WACK  = 8'h10,
    MCC_ST_READ  = 8'h20,
    MCC_ST_RACK  = 8'h40,
    MCC_ST_RNEXT = 8'h80
  } mcc_i2c_state_t;

  function automatic logic [7:0] mcc_ptr_inc(input logic [7:0] ptr);
    mcc_ptr_inc = ptr + 8'h01;
  endfunction

endpackage

/* mcc_sync.sv */
`timescale 1ns/1ns
module mcc_sync
  import mcc_pkg::*;
#(
  parameter int WIDTH = MCC_SYNC_WIDTH
) (
  // Clock and reset
  input wire logic sys_clk,
  input wire logic rst,
  // Asynchronous levels in, synchronised levels out
  input wire logic [WIDTH-1:0] async_in,
  output logic [WIDTH-1:0] sync_out
);

  logic [WIDTH-1:0] stage1;

  always_ff @(posedge sys_clk or posedge rst) begin
    if (rst) begin
      stage1 <= '0;
      sync_out <= '0;
    end else begin
      stage1 <= async_in;
      sync_out <= stage1;
    end
  end

endmodule

/* mcc_comparator.sv */
`timescale 1ns/1ns
module mcc_comparator (
  // Clock and reset
  input wire logic sys_clk,
  input wire logic rst,
  // Synchronised threshold results
  input wire logic above_high_ref,
  input wire logic above_low_ref,
  // Configuration
  input wire logic comparator_reference_select,
  input wire logic comparator_polarity_select,
  // Open-drain output pin
  output logic comparator_output_o,
  output logic comparator_output_oe
);

  logic above;
  logic pull_low;

  // ---------------------------------------------------------------
  // Reference and polarity
  // ---------------------------------------------------------------
  always_comb begin
    above = comparator_reference_select ? above_low_ref : above_high_ref;
    pull_low = comparator_polarity_select ? ~above : above;
  end

  always_ff @(posedge sys_clk or posedge rst) begin
    if (rst) begin
      comparator_output_o <= 1'b0;
      comparator_output_oe <= 1'b0;
    end else begin
      comparator_output_o <= 1'b0;
      comparator_output_oe <= pull_low;
    end
  end

  // ---------------------------------------------------------------
  // Checks
  // ---------------------------------------------------------------
  property p_comparator_reference_select_high;
    @(posedge sys_clk) disable iff (rst)
    (!comparator_reference_select && !comparator_polarity_select && above_high_ref)
      |=> comparator_output_oe;
  endproperty
  a_comparator_reference_select_high: assert property (p_comparator_reference_select_high)
    else $error("comparator not low above high reference");

  property p_comparator_polarity_select_inv;
    @(posedge sys_clk) disable iff (rst)
    (comparator_reference_select && comparator_polarity_select && !above_low_ref)
      |=> comparator_output_oe;
  endproperty
  a_comparator_polarity_select_inv: assert property (p_comparator_polarity_select_inv)
    else $error("inverted comparator not low below low reference");

endmodule

/* mcc_monitor_comparator_config.sv */
`timescale 1ns/1ns
module mcc_monitor_comparator_config
  import mcc_pkg::*;
(
  // Clock and reset
  input wire logic sys_clk,
  input wire logic rst,
  // Serial host bus
  input wire logic scl_i,
  input wire logic sda_i,
  output logic sda_o,
  output logic sda_oe,
  // Power mode from device logic
  input wire logic low_power_mode_enable,
  // Comparator threshold pins and open-drain output
  input wire logic comparator_above_high_ref,
  input wire logic comparator_above_low_ref,
  output logic comparator_output_o,
  output logic comparator_output_oe,
  // Monitor controls
  output logic battery_current_monitor_output_enable,
  output logic system_power_monitor_output_enable,
  output logic system_power_monitor_include_battery,
  output logic system_power_gain_select,
  output logic lowpower_hot_alert_enable,
  // Sense resistor selection and scaling
  output logic input_sense_resistor_select,
  output logic charge_sense_resistor_select,
  output logic [7:0] input_current_lsb_ma,
  // Comparator configuration
  output logic comparator_reference_select,
  output logic comparator_polarity_select
);

  logic [MCC_SYNC_WIDTH-1:0] sync_bus;
  logic scl, sda, cmp_above_high, cmp_above_low;
  logic scl_d, sda_d, scl_rise, scl_fall, start_det, stop_det;
  mcc_i2c_state_t state;
  logic [3:0] bit_cnt;
  logic [7:0] rx_shift, tx_shift, ptr;
  logic ptr_valid, rw_read, wr_en;
  logic [7:0] wr_addr, wr_data, rd_byte;
  logic [15:0] cfg;
  logic [1:0] system_power_monitor_output_sel;

  // ---------------------------------------------------------------
  // Pin synchronisers
  // ---------------------------------------------------------------
  mcc_sync #(
    .WIDTH(MCC_SYNC_WIDTH)
  ) u_sync (
    .sys_clk(sys_clk),
    .rst(rst),
    .async_in({comparator_above_low_ref, comparator_above_high_ref, sda_i, scl_i}),
    .sync_out(sync_bus)
  );

  assign scl = sync_bus[0];
  assign sda = sync_bus[1];
  assign cmp_above_high = sync_bus[2];
  assign cmp_above_low = sync_bus[3];

  always_ff @(posedge sys_clk or posedge rst) begin
    if (rst) begin
      scl_d <= 1'b0;
      sda_d <= 1'b0;
    end else begin
      scl_d <= scl;
      sda_d <= sda;
    end
  end

  assign scl_rise = scl & ~scl_d;
  assign scl_fall = ~scl & scl_d;
  assign start_det = scl & scl_d & sda_d & ~sda;
  assign stop_det = scl & scl_d & ~sda_d & sda;

  // ---------------------------------------------------------------
  // Read data mux
  // ---------------------------------------------------------------
  always_comb begin
    if (ptr == MCC_ADDR_LO) begin
      rd_byte = cfg[7:0];
    end else if (ptr == MCC_ADDR_HI) begin
      rd_byte = cfg[15:8];
    end else begin
      rd_byte = MCC_UNMAPPED_READ;
    end
  end

  // ---------------------------------------------------------------
  // Serial bus engine
  // ---------------------------------------------------------------
  always_ff @(posedge sys_clk or posedge rst) begin
    if (rst) begin
      state <= MCC_ST_IDLE;
      bit_cnt <= 4'h0;
      rx_shift <= 8'h00;
      tx_shift <= 8'h00;
      ptr <= 8'h00;
      ptr_valid <= 1'b0;
      rw_read <= 1'b0;
      wr_en <= 1'b0;
      wr_addr <= 8'h00;
      wr_data <= 8'h00;
      sda_oe <= 1'b0;
      sda_o <= 1'b0;
    end else begin
      wr_en <= 1'b0;
      sda_o <= 1'b0;
      if (start_det) begin
        state <= MCC_ST_ADDR;
        bit_cnt <= 4'h0;
        sda_oe <= 1'b0;
      end else if (stop_det) begin
        state <= MCC_ST_IDLE;
        sda_oe <= 1'b0;
      end else begin
        unique case (state)
          MCC_ST_IDLE: begin
          end
          MCC_ST_ADDR, MCC_ST_WRITE: begin
            if (scl_rise) begin
              rx_shift <= {rx_shift[6:0], sda};
              bit_cnt <= bit_cnt + 4'h1;
            end else if (scl_fall && bit_cnt == MCC_BYTE_BITS) begin
              bit_cnt <= 4'h0;
              if (state == MCC_ST_ADDR) begin
                if (rx_shift[7:1] == MCC_DEV_ADDR) begin
                  sda_oe <= 1'b1;
                  rw_read <= rx_shift[0];
                  if (!rx_shift[0]) begin
                    ptr_valid <= 1'b0;
                  end
                  state <= MCC_ST_AACK;
                end else begin
                  state <= MCC_ST_IDLE;
                end
              end else begin
                sda_oe <= 1'b1;
                state <= MCC_ST_WACK;
                if (!ptr_valid) begin
                  ptr <= rx_shift;
                  ptr_valid <= 1'b1;
                end else begin
                  wr_en <= 1'b1;
                  wr_addr <= ptr;
                  wr_data <= rx_shift;
                  ptr <= mcc_ptr_inc(ptr);
                end
              end
            end
          end
          MCC_ST_AACK, MCC_ST_RNEXT: begin
            if (scl_fall) begin
              if (state == MCC_ST_RNEXT || rw_read) begin
                tx_shift <= rd_byte;
                sda_oe <= ~rd_byte[7];
                ptr <= mcc_ptr_inc(ptr);
                state <= MCC_ST_READ;
              end else begin
                sda_oe <= 1'b0;
                state <= MCC_ST_WRITE;
              end
            end
          end
          MCC_ST_WACK: begin
            if (scl_fall) begin
              sda_oe <= 1'b0;
              state <= MCC_ST_WRITE;
            end
          end
          MCC_ST_READ: begin
            if (scl_rise) begin
              bit_cnt <= bit_cnt + 4'h1;
            end else if (scl_fall) begin
              if (bit_cnt == MCC_BYTE_BITS) begin
                bit_cnt <= 4'h0;
                sda_oe <= 1'b0;
                state <= MCC_ST_RACK;
              end else begin
                tx_shift <= {tx_shift[6:0], 1'b0};
                sda_oe <= ~tx_shift[6];
              end
            end
          end
          MCC_ST_RACK: begin
            if (scl_rise) begin
              state <= sda ? MCC_ST_IDLE : MCC_ST_RNEXT;
            end
          end
        endcase
      end
    end
  end

  // ---------------------------------------------------------------
  // Configuration word
  // ---------------------------------------------------------------
  always_ff @(posedge sys_clk or posedge rst) begin
    if (rst) begin
      cfg <= MCC_CFG_RESET;
    end else if (wr_en) begin
      if (wr_addr == MCC_ADDR_LO) begin
        cfg[7:0] <= wr_data;
      end else if (wr_addr == MCC_ADDR_HI) begin
        cfg[15:8] <= wr_data;
      end
    end
  end

  assign system_power_monitor_output_sel = cfg[MCC_BIT_SYSTEM_POWER_MONITOR_OUTPUT_HI:MCC_BIT_SYSTEM_POWER_MONITOR_OUTPUT_LO];

  // ---------------------------------------------------------------
  // Monitor and sense controls
  // ---------------------------------------------------------------
  always_ff @(posedge sys_clk or posedge rst) begin
    if (rst) begin
      battery_current_monitor_output_enable <= 1'b0;
      system_power_monitor_output_enable <= 1'b0;
      system_power_monitor_include_battery <= 1'b0;
      system_power_gain_select <= MCC_CFG_RESET[MCC_BIT_GAIN];
      lowpower_hot_alert_enable <= MCC_CFG_RESET[MCC_BIT_HOT_LP];
      input_sense_resistor_select <= MCC_CFG_RESET[MCC_BIT_RIN];
      charge_sense_resistor_select <= MCC_CFG_RESET[MCC_BIT_RCHG];
      input_current_lsb_ma <= MCC_IIN_LSB_5MOHM;
      comparator_reference_select <= MCC_CFG_RESET[MCC_BIT_COMPARATOR_REFERENCE_SELECT];
      comparator_polarity_select <= MCC_CFG_RESET[MCC_BIT_COMPARATOR_POLARITY_SELECT];
    end else begin
      battery_current_monitor_output_enable <= cfg[MCC_BIT_BATTERY_CURRENT_MONITOR_OUTPUT_EN] &
        ~low_power_mode_enable;
      // Reserved select code is treated like off
      system_power_monitor_output_enable <= ~low_power_mode_enable &
        (system_power_monitor_output_sel == MCC_SYSTEM_POWER_MONITOR_OUTPUT_BUS_BAT || system_power_monitor_output_sel == MCC_SYSTEM_POWER_MONITOR_OUTPUT_BUS);
      system_power_monitor_include_battery <= ~low_power_mode_enable &
        (system_power_monitor_output_sel == MCC_SYSTEM_POWER_MONITOR_OUTPUT_BUS_BAT);
      system_power_gain_select <= cfg[MCC_BIT_GAIN];
      lowpower_hot_alert_enable <= cfg[MCC_BIT_HOT_LP];
      input_sense_resistor_select <= cfg[MCC_BIT_RIN];
      charge_sense_resistor_select <= cfg[MCC_BIT_RCHG];
      input_current_lsb_ma <= cfg[MCC_BIT_RIN] ? MCC_IIN_LSB_5MOHM : MCC_IIN_LSB_10MOHM;
      comparator_reference_select <= cfg[MCC_BIT_COMPARATOR_REFERENCE_SELECT];
      comparator_polarity_select <= cfg[MCC_BIT_COMPARATOR_POLARITY_SELECT];
    end
  end

  // ---------------------------------------------------------------
  // Independent comparator
  // ---------------------------------------------------------------
  mcc_comparator u_cmp (
    .sys_clk(sys_clk),
    .rst(rst),
    .above_high_ref(cmp_above_high),
    .above_low_ref(cmp_above_low),
    .comparator_reference_select(comparator_reference_select),
    .comparator_polarity_select(comparator_polarity_select),
    .comparator_output_o(comparator_output_o),
    .comparator_output_oe(comparator_output_oe)
  );

  // ---------------------------------------------------------------
  // Checks
  // ---------------------------------------------------------------
  property p_hi_write;
    @(posedge sys_clk) disable iff (rst)
    (wr_en && wr_addr == MCC_ADDR_HI) |=> ##2 (cfg[15:8] == $past(wr_data, 3)) &&
      (battery_current_monitor_output_enable ==
       ($past(wr_data[7], 3) && !$past(low_power_mode_enable)));
  endproperty
  a_hi_write: assert property (p_hi_write)
    else $error("high byte write not reflected in controls");
  property p_battery_current_monitor_output_on;
    @(posedge sys_clk) disable iff (rst)
    (cfg[MCC_BIT_BATTERY_CURRENT_MONITOR_OUTPUT_EN] && !low_power_mode_enable) |=> battery_current_monitor_output_enable;
  endproperty
  a_battery_current_monitor_output_on: assert property (p_battery_current_monitor_output_on)
    else $error("battery current buffer not enabled");
  property p_battery_current_monitor_output_lp;
    @(posedge sys_clk) disable iff (rst)
    low_power_mode_enable[*2] |-> !battery_current_monitor_output_enable;
  endproperty
  a_battery_current_monitor_output_lp: assert property (p_battery_current_monitor_output_lp)
    else $error("battery current buffer on in low power mode");
  property p_system_power_monitor_output_off;
    @(posedge sys_clk) disable iff (rst)
    (system_power_monitor_output_sel == MCC_SYSTEM_POWER_MONITOR_OUTPUT_OFF || system_power_monitor_output_sel == MCC_SYSTEM_POWER_MONITOR_OUTPUT_RSVD) |=>
      !system_power_monitor_output_enable && !system_power_monitor_include_battery;
  endproperty
  a_system_power_monitor_output_off: assert property (p_system_power_monitor_output_off)
    else $error("system power monitor on while deselected");
  property p_system_power_monitor_output_bus;
    @(posedge sys_clk) disable iff (rst)
    (system_power_monitor_output_sel == MCC_SYSTEM_POWER_MONITOR_OUTPUT_BUS && !low_power_mode_enable) |=>
      system_power_monitor_output_enable && !system_power_monitor_include_battery;
  endproperty
  a_system_power_monitor_output_bus: assert property (p_system_power_monitor_output_bus)
    else $error("input-only system power mode wrong");
  property p_system_power_monitor_output_lp;
    @(posedge sys_clk) disable iff (rst)
    low_power_mode_enable |=> !system_power_monitor_output_enable;
  endproperty
  a_system_power_monitor_output_lp: assert property (p_system_power_monitor_output_lp)
    else $error("system power sensing on in low power mode");
  property p_sense_sel;
    @(posedge sys_clk) disable iff (rst)
    ##1 (input_sense_resistor_select == $past(cfg[MCC_BIT_RIN])) &&
      (charge_sense_resistor_select == $past(cfg[MCC_BIT_RCHG]));
  endproperty
  a_sense_sel: assert property (p_sense_sel)
    else $error("sense resistor selection does not follow register");
  property p_iin_lsb;
    @(posedge sys_clk) disable iff (rst)
    ##1 input_current_lsb_ma ==
      ($past(cfg[MCC_BIT_RIN]) ? MCC_IIN_LSB_5MOHM : MCC_IIN_LSB_10MOHM);
  endproperty
  a_iin_lsb: assert property (p_iin_lsb)
    else $error("input current step does not match sense resistor");
  property p_gain;
    @(posedge sys_clk) disable iff (rst)
    $changed(cfg[MCC_BIT_GAIN]) |=> system_power_gain_select == $past(cfg[MCC_BIT_GAIN]);
  endproperty
  a_gain: assert property (p_gain)
    else $error("system power gain select not updated");

endmodule

/* mcc_host_model.sv */
`timescale 1ns/1ns
module mcc_host_model
  import mcc_pkg::*;
(
  // Clock
  input wire logic sys_clk,
  // Bus lines; SDA is only ever pulled low, the pull-up gives the high level
  input wire logic sda_in,
  output logic scl_out,
  output logic sda_low
);
  initial begin
    scl_out = 1'b1;
    sda_low = 1'b0;
  end

  task automatic tick(input int n);
    repeat (n) @(negedge sys_clk);
  endtask

  task automatic start_cond;
    sda_low = 1'b0;
    tick(5);
    scl_out = 1'b1;
    tick(10);
    sda_low = 1'b1;
    tick(10);
    scl_out = 1'b0;
    tick(5);
  endtask

  task automatic stop_cond;
    sda_low = 1'b1;
    tick(5);
    scl_out = 1'b1;
    tick(10);
    sda_low = 1'b0;
    tick(10);
  endtask

  task automatic send_bit(input logic b);
    sda_low = ~b;
    tick(5);
    scl_out = 1'b1;
    tick(10);
    scl_out = 1'b0;
    tick(5);
  endtask

  task automatic get_bit(output logic b);
    sda_low = 1'b0;
    tick(5);
    scl_out = 1'b1;
    tick(5);
    b = sda_in;
    tick(5);
    scl_out = 1'b0;
    tick(5);
  endtask

  task automatic send_byte(input logic [7:0] d, output logic ack);
    logic a;
    for (int i = 7; i >= 0; i--) begin
      send_bit(d[i]);
    end
    get_bit(a);
    ack = ~a;
  endtask

  task automatic get_byte(output logic [7:0] d, input logic last);
    logic b;
    for (int i = 7; i >= 0; i--) begin
      get_bit(b);
      d[i] = b;
    end
    send_bit(last);
  endtask

  // Pointer write followed by n data bytes, low byte first
  task automatic wr(input logic [7:0] ptr, input logic [15:0] data, input int n,
                    output logic ok);
    logic a;
    start_cond();
    send_byte({MCC_DEV_ADDR, 1'b0}, a);
    ok = a;
    send_byte(ptr, a);
    ok = ok & a;
    for (int i = 0; i < n; i++) begin
      send_byte(data[8*i+:8], a);
      ok = ok & a;
    end
    stop_cond();
  endtask

  // Pointer set, repeated start, two bytes read, last one not acknowledged
  task automatic rd(input logic [7:0] ptr, output logic [15:0] data, output logic ok);
    logic a;
    logic [7:0] lo;
    logic [7:0] hi;
    start_cond();
    send_byte({MCC_DEV_ADDR, 1'b0}, a);
    ok = a;
    send_byte(ptr, a);
    ok = ok & a;
    start_cond();
    send_byte({MCC_DEV_ADDR, 1'b1}, a);
    ok = ok & a;
    get_byte(lo, 1'b0);
    get_byte(hi, 1'b1);
    stop_cond();
    data = {hi, lo};
  endtask

  task automatic probe(input logic [6:0] addr, output logic ack);
    start_cond();
    send_byte({addr, 1'b0}, ack);
    stop_cond();
  endtask
endmodule

/* tb_monitor_comparator_config.sv */
`timescale 1ns/1ns
module tb_monitor_comparator_config
  import mcc_pkg::*;
;
  logic sys_clk;
  logic rst;
  logic scl;
  logic host_low;
  logic sda_line;
  logic dut_sda_o;
  logic dut_sda_oe;
  logic lp;
  logic ah;
  logic al;
  logic cmp_oe;
  logic cmp_o;
  logic bat_en;
  logic sys_en;
  logic incl;
  logic gain;
  logic hot;
  logic rin;
  logic rchg;
  logic [7:0] lsb;
  logic cref;
  logic cpol;
  logic [15:0] seen_ctl;
  logic [31:0] seed;
  int mismatches;
  int compares;
  int cycles;

  assign sda_line = (dut_sda_oe ? dut_sda_o : 1'b1) & ~host_low;
  assign seen_ctl = {7'h00, bat_en, sys_en, incl, gain, hot, rin, rchg, cref, cpol};

  mcc_monitor_comparator_config dut_u (
    .sys_clk(sys_clk), .rst(rst), .scl_i(scl), .sda_i(sda_line), .sda_o(dut_sda_o),
    .sda_oe(dut_sda_oe), .low_power_mode_enable(lp), .comparator_above_high_ref(ah),
    .comparator_above_low_ref(al), .comparator_output_o(cmp_o), .comparator_output_oe(cmp_oe),
    .battery_current_monitor_output_enable(bat_en), .system_power_monitor_output_enable(sys_en),
    .system_power_monitor_include_battery(incl), .system_power_gain_select(gain),
    .lowpower_hot_alert_enable(hot), .input_sense_resistor_select(rin),
    .charge_sense_resistor_select(rchg), .input_current_lsb_ma(lsb),
    .comparator_reference_select(cref), .comparator_polarity_select(cpol)
  );

  mcc_host_model host_u (.sys_clk(sys_clk), .sda_in(sda_line), .scl_out(scl), .sda_low(host_low));

  // ---------------------------------------------------------------
  // Expectations
  // ---------------------------------------------------------------
  function automatic logic [15:0] exp_ctl(input logic [15:0] c, input logic l);
    logic [1:0] s;
    s = c[MCC_BIT_SYSTEM_POWER_MONITOR_OUTPUT_HI:MCC_BIT_SYSTEM_POWER_MONITOR_OUTPUT_LO];
    exp_ctl = {7'h00, c[MCC_BIT_BATTERY_CURRENT_MONITOR_OUTPUT_EN] & ~l,
               ((s == MCC_SYSTEM_POWER_MONITOR_OUTPUT_BUS_BAT) || (s == MCC_SYSTEM_POWER_MONITOR_OUTPUT_BUS)) & ~l,
               (s == MCC_SYSTEM_POWER_MONITOR_OUTPUT_BUS_BAT) & ~l, c[MCC_BIT_GAIN], c[MCC_BIT_HOT_LP],
               c[MCC_BIT_RIN], c[MCC_BIT_RCHG], c[MCC_BIT_COMPARATOR_REFERENCE_SELECT], c[MCC_BIT_COMPARATOR_POLARITY_SELECT]};
  endfunction

  function automatic logic exp_cmp(input logic [15:0] c, input logic h, input logic w);
    logic above;
    above = c[MCC_BIT_COMPARATOR_REFERENCE_SELECT] ? w : h;
    exp_cmp = c[MCC_BIT_COMPARATOR_POLARITY_SELECT] ? ~above : above;
  endfunction

  function automatic logic [31:0] rnd();
    seed = seed ^ (seed << 13);
    seed = seed ^ (seed >> 17);
    seed = seed ^ (seed << 5);
    rnd = seed;
  endfunction

  task automatic check(input logic [15:0] seen, input logic [15:0] exp);
    compares++;
    if (seen !== exp) begin
      mismatches++;
      $display("MISMATCH t=%0t seen %h expected %h", $time, seen, exp);
    end
  endtask

  task automatic give_verdict;
    if (mismatches == 0 && compares > 0) begin
      $display("Testbench passed");
    end else begin
      $display("Testbench failed");
    end
    $finish;
  endtask

  // ---------------------------------------------------------------
  // Clock and timeout
  // ---------------------------------------------------------------
  initial begin
    sys_clk = 1'b0;
    forever #20 sys_clk = ~sys_clk;
  end

  always @(posedge sys_clk) begin
    cycles <= cycles + 1;
    if (cycles == 80000) begin
      mismatches++;
      give_verdict();
    end
  end

  // ---------------------------------------------------------------
  // Main sequence
  // ---------------------------------------------------------------
  initial begin
    logic [31:0] r;
    logic [15:0] cfg;
    logic [15:0] d;
    logic ok;
    seed = 32'h83B2;
    mismatches = 0;
    compares = 0;
    cycles = 0;
    rst = 1'b1;
    lp = 1'b0;
    ah = 1'b0;
    al = 1'b0;
    repeat (12) @(negedge sys_clk);
    rst = 1'b0;
    repeat (6) @(negedge sys_clk);
    check(seen_ctl, exp_ctl(MCC_CFG_RESET, 1'b0));
    check({8'h00, lsb}, {8'h00, MCC_IIN_LSB_5MOHM});
    host_u.rd(MCC_ADDR_LO, d, ok);
    check({d[15:1], ok}, {MCC_CFG_RESET[15:1], 1'b1});
    for (int i = 0; i < 12; i++) begin
      r = rnd();
      cfg = r[15:0];
      cfg[8] = 1'b1;
      lp = r[16];
      // Hot-alert bit forced clear when r[20] is set, otherwise left as drawn
      if (r[20]) begin
        cfg[MCC_BIT_HOT_LP] = 1'b0;
      end
      ah = r[17];
      al = r[18];
      // Corner cases: every select code, comparator setting and power mode
      if (i < 4) begin
        cfg[MCC_BIT_SYSTEM_POWER_MONITOR_OUTPUT_HI:MCC_BIT_SYSTEM_POWER_MONITOR_OUTPUT_LO] = i[1:0];
        cfg[MCC_BIT_BATTERY_CURRENT_MONITOR_OUTPUT_EN] = 1'b1;
        cfg[MCC_BIT_COMPARATOR_REFERENCE_SELECT] = i[1];
        cfg[MCC_BIT_COMPARATOR_POLARITY_SELECT] = i[0];
        lp = i[1];
        ah = ~i[0];
        al = 1'b0;
      end
      if (i[0]) begin
        host_u.wr(MCC_ADDR_LO, cfg, 2, ok);
      end else begin
        host_u.wr(MCC_ADDR_HI, {8'h00, cfg[15:8]}, 1, ok);
        host_u.wr(MCC_ADDR_LO, cfg, 1, ok);
      end
      repeat (8) @(negedge sys_clk);
      check(seen_ctl, exp_ctl(cfg, lp));
      check({8'h00, lsb}, {8'h00, cfg[11] ? MCC_IIN_LSB_5MOHM : MCC_IIN_LSB_10MOHM});
      check({15'h0000, cmp_oe}, {15'h0000, exp_cmp(cfg, ah, al)});
      check({14'h0000, dut_sda_o, cmp_o}, 16'h0000);
      host_u.rd(MCC_ADDR_LO, d, ok);
      check(d, cfg);
      check({15'h0000, ok}, 16'h0001);
    end
    host_u.wr(8'h32, 16'h00FF, 1, ok);
    host_u.rd(8'h32, d, ok);
    check(d, {MCC_UNMAPPED_READ, MCC_UNMAPPED_READ});
    host_u.rd(MCC_ADDR_LO, d, ok);
    check(d, cfg);
    host_u.probe(MCC_DEV_ADDR ^ 7'h01, ok);
    check({15'h0000, ok}, 16'h0000);
    rst = 1'b1;
    repeat (2) @(negedge sys_clk);
    rst = 1'b0;
    lp = 1'b0;
    repeat (6) @(negedge sys_clk);
    check(seen_ctl, exp_ctl(MCC_CFG_RESET, 1'b0));
    check({8'h00, lsb}, {8'h00, MCC_IIN_LSB_5MOHM});
    host_u.rd(MCC_ADDR_LO, d, ok);
    check(d, MCC_CFG_RESET);
    give_verdict();
  end
endmodule
